//--- rtl/acdd_regs.vh
`ifndef ACDD_REGS_VH
`define ACDD_REGS_VH
// Wishbone register word offsets (byte addresses)
`define ACDD_ADR_CTRL      8'h00
`define ACDD_ADR_GAIN      8'h04
`define ACDD_ADR_AUXL      8'h08
`define ACDD_ADR_AUXR      8'h0C
`define ACDD_ADR_DACATT    8'h10
`define ACDD_ADR_STATUS    8'h14
`define ACDD_ADR_CAPTL     8'h18
`define ACDD_ADR_CAPTR     8'h1C
// CTRL fields
`define ACDD_CTRL_FMT      1:0
`define ACDD_CTRL_MONO     2
`define ACDD_CTRL_XSEL     3
`define ACDD_CTRL_RATE     7:4
`define ACDD_CTRL_SRC      9:8
`define ACDD_CTRL_MONATT   15:10
`define ACDD_CTRL_MONMUTE  16
`define ACDD_CTRL_CLOR     17
`define ACDD_CTRL_RST      32'h0002_0000
// Formats
`define ACDD_FMT_LIN16     2'h0
`define ACDD_FMT_U8        2'h1
`define ACDD_FMT_ULAW      2'h2
`define ACDD_FMT_ALAW      2'h3
// Frame geometry
`define ACDD_SLOTS         6'h20
`define ACDD_SLOT_BITS     5'h10
`define ACDD_SLOT_PLAYL    5'h01
`define ACDD_SLOT_PLAYR    5'h02
`define ACDD_SLOT_CAPL     5'h04
`define ACDD_SLOT_CAPR     5'h05
// Zero-cross timeout in sample periods
`define ACDD_ZC_TIMEOUT    9'h180
// Attenuation: 1.5 dB steps, mute code
`define ACDD_ATT_MUTE      7'h40
`define ACDD_FULL_POS      16'h7FFF
`define ACDD_FULL_NEG      16'h8000
`endif

//--- rtl/acdd_top.v
`timescale 1ns/1ps
`include "acdd_regs.vh"
module acdd_top (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire [7:0]  adr_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    input  wire        we_i,
    input  wire [3:0]  sel_i,
    input  wire        cyc_i,
    input  wire        stb_i,
    output reg         ack_o,
    input  wire        sclk_i,
    input  wire        sfs_i,
    input  wire        sdi_i,
    output reg         sdo_o,
    output reg         sdo_oe_o,
    input  wire [15:0] adc_l_i,
    input  wire [15:0] adc_r_i,
    input  wire        adc_ovr_l_i,
    input  wire        adc_ovr_r_i,
    output reg  [15:0] dac_l_o,
    output reg  [15:0] dac_r_o,
    output reg  [3:0]  gain_l_o,
    output reg  [3:0]  gain_r_o,
    output reg  [1:0]  source_o,
    output reg         mono_o,
    output reg  [5:0]  aux_l_gain_o,
    output reg  [5:0]  aux_r_gain_o,
    output reg  [1:0]  aux_mute_o,
    output reg         crystal_sel_o,
    output reg  [3:0]  rate_sel_o
);
    reg  [31:0] ctrl;
    reg  [15:0] gainreg;
    reg  [15:0] auxl;
    reg  [15:0] auxr;
    reg  [6:0]  att_req_l;
    reg  [6:0]  att_req_r;
    reg  [1:0]  ovr;
    reg  [2:0]  sclk_s;
    reg  [1:0]  sfs_s;
    reg  [1:0]  sdi_s;
    reg  [4:0]  bitcnt;
    reg  [4:0]  slot;
    reg  [15:0] rx_sh;
    reg  [15:0] tx_sh;
    reg  [15:0] play_l;
    reg  [15:0] play_r;
    reg  [15:0] cap_l;
    reg  [15:0] cap_r;
    reg         frame_end;

    // Unsigned 8 bit, mu-law and A-law expansion to 16-bit linear
    function [15:0] expand;
        input [1:0] fmt;
        input [7:0] b;
        reg   [7:0] c;
        reg  [14:0] mag;
        begin
            c   = 8'h00;
            mag = 15'h0000;
            case (fmt)
                `ACDD_FMT_U8:   expand = {~b[7], b[6:0], 8'h00};
                `ACDD_FMT_ULAW: begin
                    c   = ~b;
                    mag = ((({11'h000, c[3:0]} << 1) + 15'h0021) << c[6:4]) - 15'h0021;
                    expand = c[7] ? -{mag[13:0], 2'h0} : {mag[13:0], 2'h0};
                end
                `ACDD_FMT_ALAW: begin
                    c   = b ^ 8'h55;
                    mag = (c[6:4] == 3'h0) ? {10'h000, c[3:0], 1'b1}
                          : (({10'h000, c[3:0], 1'b1} + 15'h0020) << (c[6:4] - 3'h1));
                    expand = c[7] ? {mag[12:0], 3'h0} : -{mag[12:0], 3'h0};
                end
                default:        expand = 16'h0000;
            endcase
        end
    endfunction

    // Compression of 16-bit linear to the selected 8-bit format
    function [15:0] compress;
        input [1:0]  fmt;
        input [15:0] s;
        reg   [15:0] m;
        reg   [2:0]  e;
        reg   [3:0]  q;
        integer      i;
        begin
            m = s[15] ? (~s + 16'h0001) : s;
            e = 3'h0;
            q = 4'h0;
            case (fmt)
                `ACDD_FMT_U8: compress = {~s[15], s[14:8], 8'h00};
                `ACDD_FMT_ULAW: begin
                    m = {2'b00, m[15:2]};
                    m = (m > 16'h1FDE) ? 16'h1FFF : (m + 16'h0021);
                    for (i = 0; i < 8; i = i + 1) begin
                        if (m[i + 5])
                            e = i[2:0];
                    end
                    q = m[e + 4'h1 +: 4];
                    compress = {~{s[15], e, q}, 8'h00};
                end
                `ACDD_FMT_ALAW: begin
                    m = {3'b000, m[15:3]};
                    if (m > 16'h0FFF)
                        m = 16'h0FFF;
                    for (i = 1; i < 8; i = i + 1) begin
                        if (m[i + 4])
                            e = i[2:0];
                    end
                    q = (e == 3'h0) ? m[4:1] : m[e +: 4];
                    compress = {{~s[15], e, q} ^ 8'h55, 8'h00};
                end
                default: compress = s;
            endcase
        end
    endfunction

    // Attenuate by n * 1.5 dB: scale by a coarse quarter-step table, then shift by n/4 (6 dB)
    function [15:0] atten;
        input [15:0] s;
        input [6:0]  n;
        reg   [31:0] p;
        reg   [16:0] k;
        begin
            // Unity is an exact 1.0 so a 0 dB setting passes samples untouched
            case (n[1:0])
                2'h0:    k = 17'h10000;
                2'h1:    k = 17'h0D744;
                2'h2:    k = 17'h0B504;
                default: k = 17'h09837;
            endcase
            p = $signed(s) * $signed({1'b0, k});
            p = $signed(p) >>> n[5:2];
            atten = (n >= `ACDD_ATT_MUTE) ? 16'h0000 : p[31:16];
        end
    endfunction

    // Link clock and pins enter through two flip-flops
    always @(posedge clk_i) begin
        if (rst_i) begin
            sclk_s <= 3'h0;
            sfs_s  <= 2'h0;
            sdi_s  <= 2'h0;
        end else begin
            sclk_s <= {sclk_s[1:0], sclk_i};
            sfs_s  <= {sfs_s[0], sfs_i};
            sdi_s  <= {sdi_s[0], sdi_i};
        end
    end

    wire sclk_rise = sclk_s[1] & ~sclk_s[2];
    wire sclk_fall = ~sclk_s[1] & sclk_s[2];
    wire [1:0] fmt = ctrl[`ACDD_CTRL_FMT];

    wire [15:0] capl_src = adc_l_i;
    wire [15:0] capr_src = ctrl[`ACDD_CTRL_MONO] ? adc_l_i : adc_r_i;

    // TDM receive and transmit: frame sync marks bit 0 of slot 0
    always @(posedge clk_i) begin
        if (rst_i) begin
            bitcnt    <= 5'h00;
            slot      <= 5'h00;
            rx_sh     <= 16'h0000;
            tx_sh     <= 16'h0000;
            play_l    <= 16'h0000;
            play_r    <= 16'h0000;
            cap_l     <= 16'h0000;
            cap_r     <= 16'h0000;
            sdo_o     <= 1'b0;
            sdo_oe_o  <= 1'b0;
            frame_end <= 1'b0;
        end else begin
            frame_end <= 1'b0;
            if (sclk_rise) begin
                if (sfs_s[1]) begin
                    bitcnt <= 5'h01;
                    slot   <= 5'h00;
                    rx_sh  <= {15'h0000, sdi_s[1]};
                end else begin
                    rx_sh  <= {rx_sh[14:0], sdi_s[1]};
                    bitcnt <= bitcnt + 5'h01;
                    if (bitcnt == `ACDD_SLOT_BITS - 5'h01) begin
                        if (slot == `ACDD_SLOT_PLAYL)
                            play_l <= (fmt == `ACDD_FMT_LIN16) ? {rx_sh[14:0], sdi_s[1]}
                                      : expand(fmt, rx_sh[14:7]);
                        if (slot == `ACDD_SLOT_PLAYR) begin
                            play_r    <= (fmt == `ACDD_FMT_LIN16) ? {rx_sh[14:0], sdi_s[1]}
                                         : expand(fmt, rx_sh[14:7]);
                            frame_end <= 1'b1;
                        end
                        bitcnt <= 5'h00;
                        slot   <= (slot == `ACDD_SLOTS - 6'h01) ? 5'h00 : slot + 5'h01;
                    end
                end
            end
            if (sclk_fall) begin
                if (bitcnt == 5'h00 && (slot == `ACDD_SLOT_CAPL || slot == `ACDD_SLOT_CAPR)) begin
                    tx_sh <= (slot == `ACDD_SLOT_CAPL) ? cap_l : cap_r;
                    sdo_o <= (slot == `ACDD_SLOT_CAPL) ? cap_l[15] : cap_r[15];
                    sdo_oe_o <= 1'b1;
                end else if (sdo_oe_o && bitcnt != 5'h00) begin
                    tx_sh <= {tx_sh[14:0], 1'b0};
                    sdo_o <= tx_sh[14];
                end else begin
                    sdo_oe_o <= 1'b0;
                end
            end
            if (frame_end) begin
                // Capture words latched straight from the converter, never from the mix
                cap_l <= (fmt == `ACDD_FMT_LIN16) ? capl_src : compress(fmt, capl_src);
                cap_r <= (fmt == `ACDD_FMT_LIN16) ? capr_src : compress(fmt, capr_src);
            end
        end
    end

    // Monitor mix and saturation
    wire [15:0] mon_l = ctrl[`ACDD_CTRL_MONMUTE] ? 16'h0000 :
                        atten(capl_src, {1'b0, ctrl[`ACDD_CTRL_MONATT]});
    wire [15:0] mon_r = ctrl[`ACDD_CTRL_MONMUTE] ? 16'h0000 :
                        atten(capr_src, {1'b0, ctrl[`ACDD_CTRL_MONATT]});
    wire [16:0] sum_l = {play_l[15], play_l} + {mon_l[15], mon_l};
    wire [16:0] sum_r = {play_r[15], play_r} + {mon_r[15], mon_r};
    wire [15:0] mix_l = (sum_l[16] != sum_l[15]) ? (sum_l[16] ? `ACDD_FULL_NEG : `ACDD_FULL_POS)
                        : sum_l[15:0];
    wire [15:0] mix_r = (sum_r[16] != sum_r[15]) ? (sum_r[16] ? `ACDD_FULL_NEG : `ACDD_FULL_POS)
                        : sum_r[15:0];

    // Per-channel zero-cross gated attenuators
    wire [15:0] mix_v [0:1];
    wire [6:0]  req_v [0:1];
    wire [15:0] out_v [0:1];
    assign mix_v[0] = mix_l;
    assign mix_v[1] = mix_r;
    assign req_v[0] = att_req_l;
    assign req_v[1] = att_req_r;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
            reg [6:0]  att_cur;
            reg [8:0]  tmo;
            reg        last_sign;
            always @(posedge clk_i) begin
                if (rst_i) begin
                    att_cur   <= `ACDD_ATT_MUTE;
                    tmo       <= 9'h000;
                    last_sign <= 1'b0;
                end else if (frame_end) begin
                    last_sign <= mix_v[ch][15];
                    if (att_cur == req_v[ch]) begin
                        tmo <= 9'h000;
                    end else if (mix_v[ch][15] != last_sign || tmo == `ACDD_ZC_TIMEOUT - 9'h001) begin
                        att_cur <= req_v[ch];
                        tmo     <= 9'h000;
                    end else begin
                        tmo <= tmo + 9'h001;
                    end
                end
            end
            assign out_v[ch] = atten(mix_v[ch], att_cur);
        end
    endgenerate

    always @(posedge clk_i) begin
        if (rst_i) begin
            dac_l_o <= 16'h0000;
            dac_r_o <= 16'h0000;
        end else if (frame_end) begin
            dac_l_o <= out_v[0];
            dac_r_o <= out_v[1];
        end
    end

    // Configuration outputs decoded from registers
    always @* begin
        gain_l_o      = gainreg[3:0];
        gain_r_o      = gainreg[7:4];
        source_o      = ctrl[`ACDD_CTRL_SRC];
        mono_o        = ctrl[`ACDD_CTRL_MONO];
        aux_l_gain_o  = auxl[5:0];
        aux_r_gain_o  = auxr[5:0];
        aux_mute_o    = {auxr[7], auxl[7]};
        crystal_sel_o = ctrl[`ACDD_CTRL_XSEL];
        rate_sel_o    = ctrl[`ACDD_CTRL_RATE];
    end

    // Wishbone slave, one wait state; CTRL writes by byte lane, DACATT byte 1 needs lanes 0 and 1
    wire        wb_req   = cyc_i & stb_i & ~ack_o;
    wire [31:0] ctrl_rst = `ACDD_CTRL_RST;
    genvar bl;
    generate
        for (bl = 0; bl < 4; bl = bl + 1) begin : g_lane
            always @(posedge clk_i) begin
                if (rst_i) begin
                    ctrl[bl*8 +: 8] <= ctrl_rst[bl*8 +: 8];
                end else if (wb_req && we_i && sel_i[bl] && adr_i == `ACDD_ADR_CTRL) begin
                    ctrl[bl*8 +: 8] <= dat_i[bl*8 +: 8];
                end
            end
        end
    endgenerate

    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o     <= 1'b0;
            dat_o     <= 32'h0000_0000;
            gainreg   <= 16'h0000;
            auxl      <= 16'h0080;
            auxr      <= 16'h0080;
            att_req_l <= `ACDD_ATT_MUTE;
            att_req_r <= `ACDD_ATT_MUTE;
            ovr       <= 2'h0;
        end else begin
            ack_o <= wb_req;
            // Overrange: follows each sample with clear-mode set, else sticky; set beats clear
            if (frame_end && ctrl[`ACDD_CTRL_CLOR])
                ovr <= {adc_ovr_r_i, adc_ovr_l_i};
            else
                ovr <= ovr | {adc_ovr_r_i, adc_ovr_l_i};
            if (wb_req && we_i && sel_i[0]) begin
                case (adr_i)
                    `ACDD_ADR_GAIN:   gainreg[7:0] <= dat_i[7:0];
                    `ACDD_ADR_AUXL:   auxl[7:0]    <= dat_i[7:0];
                    `ACDD_ADR_AUXR:   auxr[7:0]    <= dat_i[7:0];
                    `ACDD_ADR_DACATT: begin
                        att_req_l <= dat_i[6:0];
                        if (sel_i[1])
                            att_req_r <= dat_i[14:8];
                    end
                    default: ;
                endcase
            end
            if (wb_req) begin
                case (adr_i)
                    `ACDD_ADR_CTRL:   dat_o <= ctrl;
                    `ACDD_ADR_GAIN:   dat_o <= {24'h000000, gainreg[7:0]};
                    `ACDD_ADR_AUXL:   dat_o <= {24'h000000, auxl[7:0]};
                    `ACDD_ADR_AUXR:   dat_o <= {24'h000000, auxr[7:0]};
                    `ACDD_ADR_DACATT: dat_o <= {17'h00000, att_req_r, 1'b0, att_req_l};
                    `ACDD_ADR_STATUS: dat_o <= {30'h00000000, ovr};
                    `ACDD_ADR_CAPTL:  dat_o <= {16'h0000, cap_l};
                    `ACDD_ADR_CAPTR:  dat_o <= {16'h0000, cap_r};
                    default:          dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule

//--- verification/acdd_dsp_port.sv
`timescale 1ns/1ps
module acdd_dsp_port (
    input  wire        run_i,
    input  wire [15:0] play_l_i,
    input  wire [15:0] play_r_i,
    input  wire        sdo_i,
    output reg         sclk_o,
    output reg         sfs_o,
    output reg         sdi_o,
    output reg  [15:0] cap_l_o,
    output reg  [15:0] cap_r_o,
    output integer     frames_o
);
    integer    b;
    reg [15:0] sh_l;
    reg [15:0] sh_r;
    initial begin
        {sclk_o, sfs_o, sdi_o} = 3'b000;
        frames_o = 0;
        #3;
        forever begin
            // Poll on the model's own grid so link edges never meet a bench clock edge
            while (!run_i)
                #80;
            for (b = 0; b < 512; b = b + 1) begin
                sfs_o = (b == 0);
                // Slots we do not own toggle, so a stale bit is never mistaken for data
                if (b / 16 == 1)
                    sdi_o = play_l_i[15 - b % 16];
                else if (b / 16 == 2)
                    sdi_o = play_r_i[15 - b % 16];
                else
                    sdi_o = ~sdi_o;
                #40 sclk_o = 1'b1;
                if (b / 16 == 4)
                    sh_l = {sh_l[14:0], sdo_i};
                if (b / 16 == 5)
                    sh_r = {sh_r[14:0], sdo_i};
                #40 sclk_o = 1'b0;
            end
            cap_l_o = sh_l;
            cap_r_o = sh_r;
            frames_o = frames_o + 1;
        end
    end
endmodule

//--- verification/acdd_top_props.sv
`timescale 1ns/1ps
`include "acdd_regs.vh"
module acdd_top_props (
    input wire       clk_i,
    input wire       rst_i,
    input wire [7:0] adr_i,
    input wire       we_i,
    input wire       cyc_i,
    input wire       stb_i,
    input wire       ack_o,
    input wire       sdo_oe_o,
    input wire [3:0] gain_l_o,
    input wire [1:0] source_o,
    input wire       mono_o,
    input wire [5:0] aux_l_gain_o,
    input wire       crystal_sel_o,
    input wire [3:0] rate_sel_o
);
    wire       wr_ctrl = ack_o && we_i && adr_i == `ACDD_ADR_CTRL;
    wire       wr_gain = ack_o && we_i && adr_i == `ACDD_ADR_GAIN;
    wire       wr_auxl = ack_o && we_i && adr_i == `ACDD_ADR_AUXL;
    reg  [9:0] oe_cnt;
    // Run length of the output enable: two slots of 16 link bits at 8 clocks each
    always @(posedge clk_i)
        if (rst_i || !sdo_oe_o)
            oe_cnt <= 10'h000;
        else
            oe_cnt <= oe_cnt + 10'h001;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req; cyc_i && stb_i && !ack_o; endsequence
    sequence s_ack_pulse; ack_o ##1 !ack_o; endsequence
    a_ack_after_req: assert property (s_req |=> s_ack_pulse) else $error("ack not a single pulse after request");
    a_ack_needs_req: assert property (!(cyc_i && stb_i) |=> !ack_o) else $error("ack without request");
    a_oe_run_len: assert property ($fell(sdo_oe_o) |-> oe_cnt inside {[10'd248:10'd264]})
        else $error("output enable run length wrong");
    a_oe_max_len: assert property (oe_cnt <= 10'd266) else $error("output enable held too long");
    a_mono_by_write: assert property ($changed(mono_o) |-> wr_ctrl || $past(wr_ctrl))
        else $error("mono moved without write");
    a_xtal_by_write: assert property ($changed(crystal_sel_o) |-> wr_ctrl || $past(wr_ctrl))
        else $error("crystal select moved without write");
    a_src_by_write: assert property (!wr_ctrl && !$past(wr_ctrl) |-> $stable(source_o))
        else $error("source moved without write");
    a_rate_by_write: assert property (!wr_ctrl && !$past(wr_ctrl) |-> $stable(rate_sel_o))
        else $error("rate moved without write");
    a_gain_by_write: assert property ($changed(gain_l_o) |-> wr_gain || $past(wr_gain))
        else $error("gain moved without write");
    a_aux_by_write: assert property ($changed(aux_l_gain_o) |-> wr_auxl || $past(wr_auxl))
        else $error("aux gain moved without write");
endmodule
bind acdd_top acdd_top_props acdd_top_props_i (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .we_i(we_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .sdo_oe_o(sdo_oe_o), .gain_l_o(gain_l_o), .source_o(source_o),
    .mono_o(mono_o), .aux_l_gain_o(aux_l_gain_o), .crystal_sel_o(crystal_sel_o), .rate_sel_o(rate_sel_o));

//--- verification/tb.sv
`timescale 1ns/1ps
`include "acdd_regs.vh"
module tb;
    reg         clk_i = 1'b0;
    reg         rst_i = 1'b1;
    reg  [7:0]  adr_i = 8'h00;
    reg  [31:0] dat_i = 32'h0;
    reg  [3:0]  sel_i = 4'h0;
    reg         we_i = 1'b0;
    reg         cyc_i = 1'b0;
    reg         stb_i = 1'b0;
    reg  [15:0] adc_l = 16'h0000;
    reg  [15:0] adc_r = 16'h0000;
    reg         ovr_l = 1'b0;
    reg         ovr_r = 1'b0;
    reg         run = 1'b0;
    reg  [15:0] play_l = 16'h0000;
    reg  [15:0] play_r = 16'h0000;
    reg  [31:0] q;
    wire [31:0] dat_o;
    wire        ack_o, sclk, sfs, sdi, sdo, sdo_oe, mono_o, xtal;
    wire [15:0] dac_l, dac_r, cap_l, cap_r;
    wire [3:0]  gain_l, gain_r, rate;
    wire [1:0]  source, aux_mute;
    wire [5:0]  aux_l, aux_r;
    integer     frames, k, err_count = 0, n_tests = 0;
    // A released data line shows the inverse of the last bit driven
    wire        sdo_line = sdo_oe ? sdo : ~sdo;
    always #5 clk_i = ~clk_i;
    acdd_top acdd_top_i (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i),
        .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .sclk_i(sclk), .sfs_i(sfs), .sdi_i(sdi),
        .sdo_o(sdo), .sdo_oe_o(sdo_oe), .adc_l_i(adc_l), .adc_r_i(adc_r), .adc_ovr_l_i(ovr_l), .adc_ovr_r_i(ovr_r),
        .dac_l_o(dac_l), .dac_r_o(dac_r), .gain_l_o(gain_l), .gain_r_o(gain_r), .source_o(source), .mono_o(mono_o),
        .aux_l_gain_o(aux_l), .aux_r_gain_o(aux_r), .aux_mute_o(aux_mute), .crystal_sel_o(xtal), .rate_sel_o(rate));
    acdd_dsp_port acdd_dsp_port_i (.run_i(run), .play_l_i(play_l), .play_r_i(play_r), .sdo_i(sdo_line),
        .sclk_o(sclk), .sfs_o(sfs), .sdi_o(sdi), .cap_l_o(cap_l), .cap_r_o(cap_r), .frames_o(frames));
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task stop_test;
        begin
            $display("Checks %0d, mismatches %0d", n_tests, err_count);
            if (err_count == 0 && n_tests > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    task wb(input [7:0] a, input [31:0] d, input w);
        integer n;
        begin
            {cyc_i, stb_i, we_i, sel_i, adr_i, dat_i} <= {2'b11, w, 4'hF, a, d};
            n = 0;
            @(posedge clk_i);
            while (ack_o !== 1'b1 && n < 50) begin
                @(posedge clk_i);
                n = n + 1;
            end
            q = dat_o;
            {cyc_i, stb_i, we_i} <= 3'b000;
            if (n >= 50) begin
                chk(32'h0, 32'h1);
                stop_test;
            end
            @(posedge clk_i);
        end
    endtask
    task frm(input integer nf);
        integer n, t;
        begin
            t = frames + nf;
            n = 0;
            while (frames < t && n < 5000 * nf) begin
                @(posedge clk_i);
                n = n + 1;
            end
            if (frames < t) begin
                chk(32'h0, 32'h1);
                stop_test;
            end
        end
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        chk(32'(xtal), 32'h0);
        chk(32'(aux_mute), 32'h3);
        wb(`ACDD_ADR_CTRL, 32'h0, 1'b0);
        chk(q, `ACDD_CTRL_RST);
        wb(`ACDD_ADR_AUXL, 32'h0, 1'b0);
        chk(q, 32'h80);
        wb(8'h40, 32'hFFFF_FFFF, 1'b1);
        wb(8'h40, 32'h0, 1'b0);
        chk(q, 32'h0);
        for (k = 0; k < 14; k = k + 1) begin
            wb(`ACDD_ADR_CTRL, 32'h0003_0000 | k << 4 | (k & 3) << 8 | (k & 3) << 2, 1'b1);
            chk(32'(source), k & 3);
            chk(32'(rate), k);
            chk(32'(mono_o), k & 1);
            chk(32'(xtal), k >> 1 & 1);
        end
        for (k = 0; k < 16; k = k + 1) begin
            wb(`ACDD_ADR_GAIN, k | (15 - k) << 4, 1'b1);
            chk(32'(gain_l), k);
            chk(32'(gain_r), 15 - k);
        end
        wb(`ACDD_ADR_AUXL, 32'h1F, 1'b1);
        wb(`ACDD_ADR_AUXR, 32'h8A, 1'b1);
        chk({aux_l, aux_r, aux_mute}, {6'h1F, 6'h0A, 2'h2});
        // Linear format with the monitor path muted
        wb(`ACDD_ADR_CTRL, 32'h0003_0000, 1'b1);
        wb(`ACDD_ADR_DACATT, 32'h0, 1'b1);
        adc_l <= 16'h1234;
        adc_r <= 16'hEDCC;
        play_l <= 16'h0100;
        play_r <= 16'h0200;
        run <= 1'b1;
        frm(2);
        play_l <= 16'hFF00;
        play_r <= 16'hFE00;
        frm(2);
        chk({cap_l, cap_r}, 32'h1234_EDCC);
        chk({dac_l, dac_r}, 32'hFF00_FE00);
        wb(`ACDD_ADR_CAPTL, 32'h0, 1'b0);
        chk(q, 32'h1234);
        wb(`ACDD_ADR_DACATT, 32'h40, 1'b1);
        frm(2);
        chk(32'(dac_l), 32'hFF00);
        play_l <= 16'h0100;
        frm(2);
        chk(32'(dac_l), 32'h0);
        wb(`ACDD_ADR_CTRL, 32'h0002_0000, 1'b1);
        adc_r <= 16'h7000;
        play_r <= 16'h7000;
        frm(2);
        chk(32'(dac_r), 32'h7FFF);
        chk(32'(cap_r), 32'h7000);
        wb(`ACDD_ADR_CTRL, 32'h0003_0001, 1'b1);
        play_r <= 16'h92AB;
        frm(2);
        chk({cap_l, cap_r}, 32'h9200_F000);
        chk(32'(dac_r), 32'h1200);
        wb(`ACDD_ADR_CTRL, 32'h0003_0002, 1'b1);
        adc_l <= 16'h0000;
        play_r <= 16'h80AB;
        frm(2);
        chk(32'(cap_l), 32'hFF00);
        chk(32'(dac_r), 32'h7D7C);
        wb(`ACDD_ADR_CTRL, 32'h0003_0003, 1'b1);
        play_r <= 16'hAA11;
        frm(2);
        chk(32'(cap_l), 32'hD500);
        chk(32'(dac_r), 32'h7E00);
        wb(`ACDD_ADR_CTRL, 32'h0003_0000, 1'b1);
        ovr_l <= 1'b1;
        frm(2);
        wb(`ACDD_ADR_STATUS, 32'h0, 1'b0);
        chk(q & 3, 32'h1);
        ovr_l <= 1'b0;
        frm(2);
        wb(`ACDD_ADR_STATUS, 32'h0, 1'b0);
        chk(q & 3, 32'h0);
        // Sticky mode: a brief overrange must survive later clean frames
        wb(`ACDD_ADR_CTRL, 32'h0001_0000, 1'b1);
        ovr_r <= 1'b1;
        frm(1);
        ovr_r <= 1'b0;
        frm(2);
        wb(`ACDD_ADR_STATUS, 32'h0, 1'b0);
        chk(q & 3, 32'h2);
        stop_test;
    end
endmodule
